// ==== design/cie_pkg.sv ====
// Purpose: shared constants for the instruction execution core
// Assumes: 16-bit instruction words, 8-bit data, 32 working registers
// Notes: opcode layout is local to this core
package cie_pkg;
  localparam int SP_W = 9;
  localparam logic [SP_W-1:0] SP_RST = 9'h000;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic RUN_RST = 1'b0;
  // Status flag positions
  localparam int FLG_C = 0;
  localparam int FLG_Z = 1;
  localparam int FLG_N = 2;
  localparam int FLG_V = 3;
  localparam int FLG_S = 4;
  localparam int FLG_H = 5;
  localparam int FLG_T = 6;
  localparam int FLG_I = 7;
  // Major opcodes in bits 15:12
  localparam logic [3:0] OP_MISC = 4'h0;
  localparam logic [3:0] OP_BR = 4'h1;
  localparam logic [3:0] OP_COPY = 4'h2;
  localparam logic [3:0] OP_IMM = 4'h3;
  localparam logic [3:0] OP_IND = 4'h4;
  localparam logic [3:0] OP_DLOAD = 4'h5;
  localparam logic [3:0] OP_DSTORE = 4'h6;
  localparam logic [3:0] OP_DIR = 4'h7;
  localparam logic [3:0] OP_IOB = 4'h8;
  localparam logic [3:0] OP_TBIT = 4'h9;
  // Minor codes of OP_MISC in bits 11:8
  localparam logic [3:0] SUB_FSET = 4'h1;
  localparam logic [3:0] SUB_FCLR = 4'h2;
  localparam logic [3:0] SUB_RLC = 4'h3;
  localparam logic [3:0] SUB_RRC = 4'h4;
  localparam logic [3:0] SUB_SRA = 4'h5;
  localparam logic [3:0] SUB_PUSH = 4'h6;
  localparam logic [3:0] SUB_POP = 4'h7;
  // Indirect addressing modes in bits 8:7
  localparam logic [1:0] AM_PLAIN = 2'h0;
  localparam logic [1:0] AM_POSTINC = 2'h1;
  localparam logic [1:0] AM_PREDEC = 2'h2;
  // Pointer low-byte register numbers
  localparam logic [4:0] PTR_X = 5'h1A;
  localparam logic [4:0] PTR_Y = 5'h1C;
  localparam logic [4:0] PTR_Z = 5'h1E;
  // Shift unit operations
  localparam logic [1:0] SH_RLC = 2'h0;
  localparam logic [1:0] SH_RRC = 2'h1;
  localparam logic [1:0] SH_SRA = 2'h2;
  // Register port offsets
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_SP_LO = 4'h1;
  localparam logic [3:0] REG_SP_HI = 4'h2;
  localparam logic [3:0] REG_CTRL = 4'h3;
  localparam logic [3:0] REG_PC_LO = 4'h4;
  localparam logic [3:0] REG_PC_HI = 4'h5;
  localparam logic [3:0] REG_STATE = 4'h6;
  typedef enum logic [3:0] {
    ST_EXEC = 4'b0001,
    ST_MEM  = 4'b0010,
    ST_IO   = 4'b0100,
    ST_BUB  = 4'b1000
  } cie_state_t;
endpackage

// ==== design/cie_shift.sv ====
// Purpose: rotate and shift unit with flag results
// Assumes: purely combinational, fed from the register file
// Notes: overflow is negative xor carry after the shift
`timescale 1ns/100ps
`default_nettype none
module cie_shift
  import cie_pkg::*;
(
  input  wire logic [1:0] i_kind,
  input  wire logic [7:0] i_val,
  input  wire logic       i_carry,
  output logic      [7:0] o_res,
  output logic            o_c,
  output logic            o_z,
  output logic            o_n,
  output logic            o_v
);
  always_comb begin
    case (i_kind)
      SH_RLC: begin
        o_res = {i_val[6:0], i_carry};
        o_c   = i_val[7];
      end
      SH_RRC: begin
        o_res = {i_carry, i_val[7:1]};
        o_c   = i_val[0];
      end
      SH_SRA: begin
        o_res = {i_val[7], i_val[7:1]};
        o_c   = i_val[0];
      end
      default: begin
        o_res = i_val;
        o_c   = i_carry;
      end
    endcase
    o_z = (o_res == 8'h00);
    o_n = o_res[7];
    o_v = o_res[7] ^ o_c;
  end
endmodule // cie_shift
`default_nettype wire

// ==== design/cie_core.sv ====
// Purpose: execution core for branches, moves, memory, bit and flag ops
// Assumes: program, data and I/O memories answer in the same cycle
// Notes: core idles until the run bit is set over the register port
//
// Local design decisions: the strobed register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module cie_core
  import cie_pkg::*;
#(
  parameter int PC_W = 12
)
(
  input  wire logic            i_mclk,
  input  wire logic            i_rst,
  output logic      [PC_W-1:0] o_pmem_addr,
  input  wire logic [15:0]     i_pmem_data,
  output logic      [15:0]     o_dmem_addr,
  output logic      [7:0]      o_dmem_wdata,
  output logic                 o_dmem_we,
  output logic                 o_dmem_re,
  input  wire logic [7:0]      i_dmem_rdata,
  output logic      [5:0]      o_io_addr,
  output logic      [7:0]      o_io_wdata,
  output logic                 o_io_we,
  output logic                 o_io_re,
  input  wire logic [7:0]      i_io_rdata,
  input  wire logic [3:0]      i_reg_addr,
  input  wire logic [7:0]      i_reg_wdata,
  input  wire logic            i_reg_wr,
  input  wire logic            i_reg_rd,
  output logic      [7:0]      o_reg_rdata,
  output logic      [7:0]      o_status_flags,
  output logic      [SP_W-1:0] o_sp
);
  typedef struct packed {
    cie_state_t       st;
    logic [PC_W-1:0]  pc;
    logic [SP_W-1:0]  sp;
    logic [7:0]       flags;
    logic [31:0][7:0] gpr;
    logic             run;
    logic [15:0]      maddr;
    logic [4:0]       mreg;
    logic             mstore;
    logic             mdirect;
    logic [7:0]       iodata;
    logic [7:0]       bus_rd;
  } cie_core_t;

  cie_core_t r;
  cie_core_t next_r;

  logic [15:0]     ins;
  logic [3:0]      major;
  logic [3:0]      sub;
  logic [4:0]      f_rd;
  logic [4:0]      ip_lo;
  logic [4:0]      ip_hi;
  logic [15:0]     ip_val;
  logic [15:0]     ip_inc;
  logic [15:0]     ip_dec;
  logic [4:0]      dp_lo;
  logic [15:0]     dp_val;
  logic [PC_W-1:0] pc_inc;
  logic [PC_W-1:0] br_off;
  logic [SP_W-1:0] sp_inc;
  logic [2:0]      bsel;
  logic [1:0]      sh_kind;
  logic [7:0]      sh_res;
  logic            sh_c;
  logic            sh_z;
  logic            sh_n;
  logic            sh_v;

  // Instruction fields
  assign ins    = i_pmem_data;
  assign major  = ins[15:12];
  assign sub    = ins[11:8];
  assign f_rd   = ins[4:0];
  assign bsel   = ins[2:0];
  assign pc_inc = r.pc + PC_W'(1);
  assign br_off = {{(PC_W-7){ins[6]}}, ins[6:0]};
  assign sp_inc = r.sp + SP_W'(1);

  // Indirect pointer X, Y or Z by bits 10:9
  assign ip_lo  = PTR_X + {2'b00, ins[10:9], 1'b0};
  assign ip_hi  = ip_lo + 5'h01;
  assign ip_val = {r.gpr[ip_hi], r.gpr[ip_lo]};
  assign ip_inc = ip_val + 16'h0001;
  assign ip_dec = ip_val - 16'h0001;

  // Displaced pointer Y or Z by bit 11
  assign dp_lo  = ins[11] ? PTR_Z : PTR_Y;
  assign dp_val = {r.gpr[dp_lo + 5'h01], r.gpr[dp_lo]};

  always_comb begin
    case (sub)
      SUB_RRC: sh_kind = SH_RRC;
      SUB_SRA: sh_kind = SH_SRA;
      default: sh_kind = SH_RLC;
    endcase
  end

  cie_shift u_shift (
    .i_kind  (sh_kind),
    .i_val   (r.gpr[f_rd]),
    .i_carry (r.flags[FLG_C]),
    .o_res   (sh_res),
    .o_c     (sh_c),
    .o_z     (sh_z),
    .o_n     (sh_n),
    .o_v     (sh_v)
  );

  always_comb begin
    next_r       = r;
    next_r.bus_rd = 8'h00;
    o_dmem_addr  = r.maddr;
    o_dmem_wdata = r.gpr[r.mreg];
    o_dmem_we    = 1'b0;
    o_dmem_re    = 1'b0;
    o_io_addr    = r.maddr[5:0];
    o_io_wdata   = r.iodata;
    o_io_we      = 1'b0;
    o_io_re      = 1'b0;
    case (r.st)
      ST_EXEC: begin
        if (r.run) begin
          next_r.pc = pc_inc;
          case (major)
            OP_MISC: begin
              case (sub)
                SUB_FSET: begin
                  next_r.flags[bsel] = 1'b1;
                end
                SUB_FCLR: begin
                  next_r.flags[bsel] = 1'b0;
                end
                SUB_RLC, SUB_RRC, SUB_SRA: begin
                  next_r.gpr[f_rd]    = sh_res;
                  next_r.flags[FLG_C] = sh_c;
                  next_r.flags[FLG_Z] = sh_z;
                  next_r.flags[FLG_N] = sh_n;
                  next_r.flags[FLG_V] = sh_v;
                end
                SUB_PUSH: begin
                  // Save at SP, then post-decrement
                  next_r.maddr   = 16'(r.sp);
                  next_r.sp      = r.sp - SP_W'(1);
                  next_r.mreg    = f_rd;
                  next_r.mstore  = 1'b1;
                  next_r.mdirect = 1'b0;
                  next_r.st      = ST_MEM;
                end
                SUB_POP: begin
                  // Pre-increment, then restore
                  next_r.sp      = sp_inc;
                  next_r.maddr   = 16'(sp_inc);
                  next_r.mreg    = f_rd;
                  next_r.mstore  = 1'b0;
                  next_r.mdirect = 1'b0;
                  next_r.st      = ST_MEM;
                end
                default: begin
                  next_r.pc = pc_inc;
                end
              endcase
            end
            OP_BR: begin
              // Taken branch adds a bubble cycle
              if (r.flags[ins[11:9]] == ins[8]) begin
                next_r.pc = pc_inc + br_off;
                next_r.st = ST_BUB;
              end
            end
            OP_COPY: begin
              next_r.gpr[ins[9:5]] = r.gpr[ins[4:0]];
            end
            OP_IMM: begin
              next_r.gpr[{1'b1, ins[11:8]}] = ins[7:0];
            end
            OP_IND: begin
              next_r.mreg    = f_rd;
              next_r.mstore  = ins[11];
              next_r.mdirect = 1'b0;
              next_r.st      = ST_MEM;
              case (ins[8:7])
                AM_POSTINC: begin
                  next_r.maddr      = ip_val;
                  next_r.gpr[ip_lo] = ip_inc[7:0];
                  next_r.gpr[ip_hi] = ip_inc[15:8];
                end
                AM_PREDEC: begin
                  next_r.maddr      = ip_dec;
                  next_r.gpr[ip_lo] = ip_dec[7:0];
                  next_r.gpr[ip_hi] = ip_dec[15:8];
                end
                default: begin
                  next_r.maddr = ip_val;
                end
              endcase
            end
            OP_DLOAD, OP_DSTORE: begin
              // Pointer itself is left alone
              next_r.maddr   = dp_val + 16'(ins[10:5]);
              next_r.mreg    = f_rd;
              next_r.mstore  = (major == OP_DSTORE);
              next_r.mdirect = 1'b0;
              next_r.st      = ST_MEM;
            end
            OP_DIR: begin
              // Address k is the following word
              next_r.mreg    = f_rd;
              next_r.mstore  = ins[11];
              next_r.mdirect = 1'b1;
              next_r.st      = ST_MEM;
            end
            OP_IOB: begin
              // Read now, write back the next cycle
              o_io_addr                 = ins[10:5];
              o_io_re                   = 1'b1;
              next_r.iodata             = i_io_rdata;
              next_r.iodata[bsel]       = ins[11];
              next_r.maddr              = 16'(ins[10:5]);
              next_r.st                 = ST_IO;
            end
            OP_TBIT: begin
              if (ins[11]) begin
                next_r.gpr[ins[8:4]][bsel] = r.flags[FLG_T];
              end else begin
                next_r.flags[FLG_T] = r.gpr[ins[8:4]][bsel];
              end
            end
            default: begin
              next_r.pc = pc_inc;
            end
          endcase
        end
      end
      ST_MEM: begin
        if (r.mdirect) begin
          o_dmem_addr = ins;
          next_r.pc   = pc_inc;
        end
        if (r.mstore) begin
          o_dmem_we = 1'b1;
        end else begin
          o_dmem_re         = 1'b1;
          next_r.gpr[r.mreg] = i_dmem_rdata;
        end
        next_r.st = ST_EXEC;
      end
      ST_IO: begin
        o_io_we   = 1'b1;
        next_r.st = ST_EXEC;
      end
      ST_BUB: begin
        next_r.st = ST_EXEC;
      end
      default: begin
        next_r.st = ST_EXEC;
      end
    endcase
    // Register port writes take priority over the core
    if (i_reg_wr) begin
      case (i_reg_addr)
        REG_STATUS: begin
          next_r.flags = i_reg_wdata;
        end
        REG_SP_LO: begin
          next_r.sp[7:0] = i_reg_wdata;
        end
        REG_SP_HI: begin
          next_r.sp[SP_W-1] = i_reg_wdata[0];
        end
        REG_CTRL: begin
          next_r.run = i_reg_wdata[0];
        end
        REG_PC_LO: begin
          next_r.pc[7:0] = i_reg_wdata;
        end
        REG_PC_HI: begin
          next_r.pc[PC_W-1:8] = i_reg_wdata[PC_W-9:0];
        end
        default: begin
          next_r.run = r.run;
        end
      endcase
    end
    // Read data stands one cycle after the strobe
    if (i_reg_rd) begin
      case (i_reg_addr)
        REG_STATUS: begin
          next_r.bus_rd = r.flags;
        end
        REG_SP_LO: begin
          next_r.bus_rd = r.sp[7:0];
        end
        REG_SP_HI: begin
          next_r.bus_rd = {7'h00, r.sp[SP_W-1]};
        end
        REG_CTRL: begin
          next_r.bus_rd = {7'h00, r.run};
        end
        REG_PC_LO: begin
          next_r.bus_rd = r.pc[7:0];
        end
        REG_PC_HI: begin
          next_r.bus_rd = 8'(r.pc[PC_W-1:8]);
        end
        REG_STATE: begin
          next_r.bus_rd = {4'h0, r.st};
        end
        default: begin
          next_r.bus_rd = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      r      <= '0;
      r.st   <= ST_EXEC;
      r.sp   <= SP_RST;
      r.flags <= FLAGS_RST;
      r.run  <= RUN_RST;
    end else begin
      r <= next_r;
    end
  end

  assign o_pmem_addr    = r.pc;
  assign o_reg_rdata    = r.bus_rd;
  assign o_status_flags = r.flags;
  assign o_sp           = r.sp;
endmodule // cie_core
`default_nettype wire

// ==== dv/cie_mem_model.sv ====
// Purpose: program, data and I/O memories seen by the core
// Assumes: combinational reads, writes at the rising edge
// Notes: unread data lines show the inverse of the last value read
`timescale 1ns/100ps
`default_nettype none
module cie_mem_model #(
  parameter int PC_W = 12
)
(
  input  wire logic            i_mclk,
  input  wire logic [PC_W-1:0] i_pm_addr,
  output logic      [15:0]     o_pm_data,
  input  wire logic [15:0]     i_dm_addr,
  input  wire logic [7:0]      i_dm_wdata,
  input  wire logic            i_dm_we,
  input  wire logic            i_dm_re,
  output logic      [7:0]      o_dm_rdata,
  input  wire logic [5:0]      i_io_addr,
  input  wire logic [7:0]      i_io_wdata,
  input  wire logic            i_io_we,
  input  wire logic            i_io_re,
  output logic      [7:0]      o_io_rdata
);
  logic [15:0] prog [0:255];
  logic [7:0]  dmem [0:511];
  logic [7:0]  io   [0:63];
  logic [7:0]  d_last  = 8'h00;
  logic [7:0]  io_last = 8'h00;
  // One word per location, k word read like any other
  assign o_pm_data  = prog[i_pm_addr[7:0]];
  assign o_dm_rdata = i_dm_re ? dmem[i_dm_addr[8:0]] : ~d_last;
  assign o_io_rdata = i_io_re ? io[i_io_addr] : ~io_last;
  // Data and stack area in one linear space
  always @(posedge i_mclk) begin
    if (i_dm_we) dmem[i_dm_addr[8:0]] <= i_dm_wdata;
    if (i_dm_re) d_last <= dmem[i_dm_addr[8:0]];
    if (i_io_we) io[i_io_addr] <= i_io_wdata;
    if (i_io_re) io_last <= io[i_io_addr];
  end
endmodule // cie_mem_model
`default_nettype wire

// ==== dv/cie_core_checker.sv ====
// Purpose: port-level checks of the execution core
// Assumes: single clock, async active-high reset
// Notes: attached by bind below
`timescale 1ns/100ps
`default_nettype none
module cie_core_checker (
  input wire logic       i_mclk,
  input wire logic       i_rst,
  input wire logic       o_dmem_we,
  input wire logic       o_dmem_re,
  input wire logic [5:0] o_io_addr,
  input wire logic [7:0] o_io_wdata,
  input wire logic       o_io_we,
  input wire logic       o_io_re,
  input wire logic [7:0] i_io_rdata,
  input wire logic       i_reg_wr,
  input wire logic [7:0] o_status_flags,
  input wire logic [8:0] o_sp
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  property p_we_pulse; o_dmem_we |=> !o_dmem_we; endproperty
  a_we_pulse: assert property (p_we_pulse) else $error("store strobe too long");
  property p_re_pulse; o_dmem_re |=> !o_dmem_re; endproperty
  a_re_pulse: assert property (p_re_pulse) else $error("load strobe too long");
  property p_io_seq; o_io_re |=> o_io_we && $stable(o_io_addr); endproperty
  a_io_seq: assert property (p_io_seq) else $error("io write missing");
  property p_io_src; o_io_we |-> $past(o_io_re); endproperty
  a_io_src: assert property (p_io_src) else $error("io write without read");
  property p_io_bit; o_io_we |-> $countones(o_io_wdata ^ $past(i_io_rdata)) <= 1; endproperty
  a_io_bit: assert property (p_io_bit) else $error("io write changed several bits");
  property p_mem_flags; (o_dmem_we || o_dmem_re) |-> $stable(o_status_flags); endproperty
  a_mem_flags: assert property (p_mem_flags) else $error("flags moved in memory op");
  property p_io_flags; o_io_we |-> $stable(o_status_flags); endproperty
  a_io_flags: assert property (p_io_flags) else $error("flags moved in io op");
  property p_sp_step;
    ($changed(o_sp) && !$past(i_reg_wr)) |-> (o_sp == $past(o_sp) + 9'h001 || o_sp == $past(o_sp) - 9'h001);
  endproperty
  a_sp_step: assert property (p_sp_step) else $error("stack pointer jumped");
  c_store: cover property (o_dmem_we);
  c_load: cover property (o_dmem_re);
  c_io: cover property (o_io_we);
  c_sp: cover property ($changed(o_sp));
endmodule // cie_core_checker
bind cie_core cie_core_checker u_chk (
  .i_mclk(i_mclk), .i_rst(i_rst), .o_dmem_we(o_dmem_we), .o_dmem_re(o_dmem_re),
  .o_io_addr(o_io_addr), .o_io_wdata(o_io_wdata), .o_io_we(o_io_we), .o_io_re(o_io_re),
  .i_io_rdata(i_io_rdata), .i_reg_wr(i_reg_wr), .o_status_flags(o_status_flags), .o_sp(o_sp)
);
`default_nettype wire

// ==== dv/cie_core_test.sv ====
// Purpose: self-checking bench of the execution core
// Assumes: memory model answers in the same cycle
// Notes: each scenario resets the core; all but t_regs then run a short program
`timescale 1ns/100ps
`default_nettype none
module cie_core_test;
  import cie_pkg::*;
  logic i_mclk = 1'b0;
  logic i_rst = 1'b1;
  logic [3:0] i_reg_addr = 4'h0;
  logic [7:0] i_reg_wdata = 8'h00;
  logic i_reg_wr = 1'b0;
  logic i_reg_rd = 1'b0;
  wire logic [11:0] pm_addr;
  wire logic [15:0] pm_data, dm_addr;
  wire logic [7:0] dm_wdata, dm_rdata, io_wdata, io_rdata, reg_rdata, flags;
  wire logic dm_we, dm_re, io_we, io_re;
  wire logic [5:0] io_addr;
  wire logic [8:0] sp;
  int failures = 0;
  int n_compared = 0;
  int cyc = 0;
  logic [15:0] prog_q[$];
  logic [7:0] d;
  initial forever #12.5 i_mclk = ~i_mclk;
  cie_core uut (.i_mclk(i_mclk), .i_rst(i_rst), .o_pmem_addr(pm_addr), .i_pmem_data(pm_data),
    .o_dmem_addr(dm_addr), .o_dmem_wdata(dm_wdata), .o_dmem_we(dm_we), .o_dmem_re(dm_re),
    .i_dmem_rdata(dm_rdata), .o_io_addr(io_addr), .o_io_wdata(io_wdata), .o_io_we(io_we),
    .o_io_re(io_re), .i_io_rdata(io_rdata), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(reg_rdata), .o_status_flags(flags), .o_sp(sp));
  cie_mem_model mdl (.i_mclk(i_mclk), .i_pm_addr(pm_addr), .o_pm_data(pm_data), .i_dm_addr(dm_addr),
    .i_dm_wdata(dm_wdata), .i_dm_we(dm_we), .i_dm_re(dm_re), .o_dm_rdata(dm_rdata), .i_io_addr(io_addr),
    .i_io_wdata(io_wdata), .i_io_we(io_we), .i_io_re(io_re), .o_io_rdata(io_rdata));
  task tally_and_finish;
    if (failures == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      tally_and_finish;
    end
  end
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task wr(input logic [3:0] a, input logic [7:0] v);
    i_reg_addr <= a;
    i_reg_wdata <= v;
    i_reg_wr <= 1'b1;
    @(posedge i_mclk);
    i_reg_wr <= 1'b0;
    @(posedge i_mclk);
  endtask
  task rd(input logic [3:0] a, output logic [7:0] v);
    i_reg_addr <= a;
    i_reg_rd <= 1'b1;
    @(posedge i_mclk);
    i_reg_rd <= 1'b0;
    #1 v = reg_rdata;
    @(posedge i_mclk);
  endtask
  task start;
    i_rst <= 1'b1;
    for (int i = 0; i < 64; i++) mdl.prog[i] = 16'h0000;
    repeat (2) @(posedge i_mclk);
    i_rst <= 1'b0;
    @(posedge i_mclk);
  endtask
  // Runs prog_q from 0, counts cycles until the word after it
  task go(input int ecyc, input string nm);
    int cnt;
    foreach (prog_q[i]) mdl.prog[i] = prog_q[i];
    i_reg_addr <= REG_CTRL;
    i_reg_wdata <= 8'h01;
    i_reg_wr <= 1'b1;
    @(posedge i_mclk);
    i_reg_wr <= 1'b0;
    cnt = 0;
    // Last instruction may still be in its memory or I/O cycle
    while ((pm_addr !== prog_q.size() || dm_we !== 1'b0 || dm_re !== 1'b0 || io_we !== 1'b0) && cnt < 200) begin
      @(posedge i_mclk);
      #1 cnt++;
    end
    chk(nm, 16'(ecyc), 16'(cnt));
    wr(REG_CTRL, 8'h00);
  endtask
  task t_regs;
    start;
    rd(REG_STATUS, d);
    chk("status reset", 16'h0000, d);
    wr(REG_SP_HI, 8'h01);
    wr(REG_SP_LO, 8'h23);
    chk("sp written", 16'h0123, sp);
    rd(REG_SP_HI, d);
    chk("sp high read", 16'h0001, d);
    rd(4'hF, d);
    chk("unmapped read", 16'h0000, d);
    rd(REG_STATE, d);
    chk("idle state", 16'(ST_EXEC), d);
  endtask
  // Half-carry, transfer, overflow, interrupt flags; trap words set carry
  task t_branch;
    logic [15:0] fl[4] = '{16'h5, 16'h6, 16'h3, 16'h7};
    foreach (fl[j]) begin
      start;
      prog_q = {16'h0100 | fl[j], 16'h1102 | (fl[j] << 9), 16'h0100, 16'h0100, 16'h1005 | (fl[j] << 9),
        16'h0200 | fl[j]};
      go(5, "branch cycles");
      chk("branch flags", 16'h0000, flags);
    end
  endtask
  task t_mem;
    logic [8:0] ea[7] = '{9'h010, 9'h01F, 9'h033, 9'h050, 9'h0FF, 9'h031, 9'h021};
    logic [7:0] ev[7] = '{8'h5A, 8'h5A, 8'h5A, 8'hC3, 8'h96, 8'hE7, 8'h96};
    start;
    wr(REG_SP_LO, 8'hFF);
    mdl.dmem[9'h011] = 8'hC3;
    mdl.dmem[9'h030] = 8'h96;
    mdl.dmem[9'h024] = 8'h3C;
    mdl.dmem[9'h040] = 8'hE7;
    prog_q = {16'h305A, 16'h2230, 16'h3A10, 16'h3B00, 16'h3C20, 16'h3D00, 16'h3E30, 16'h3F00, 16'h4891,
      16'h4B10, 16'h6871, 16'h4012, 16'h4493, 16'h50B4, 16'h7015, 16'h0040, 16'h7812, 16'h0050, 16'h0613,
      16'h0716, 16'h4C15, 16'h6056};
    go(32, "memory cycles");
    chk("memory flags", 16'h0000, flags);
    chk("sp after pop", 16'h00FF, sp);
    foreach (ea[i]) chk("data byte", 16'(ev[i]), 16'(mdl.dmem[ea[i]]));
  endtask
  task t_bits;
    start;
    mdl.io[5] = 8'hF0;
    prog_q = {16'h88A0, 16'h80A7, 16'h3081, 16'h0100, 16'h0310, 16'h0410, 16'h0510, 16'h9106, 16'h9913,
      16'h7810, 16'h0060, 16'h7811, 16'h0061};
    go(15, "bit cycles");
    chk("shift flags", 16'h0045, flags);
    chk("io byte", 16'h0071, 16'(mdl.io[5]));
    chk("shift result", 16'h00C0, 16'(mdl.dmem[9'h060]));
    chk("bit load", 16'h0008, 16'(mdl.dmem[9'h061]));
  endtask
  initial begin
    repeat (6) @(posedge i_mclk);
    i_rst <= 1'b0;
    @(posedge i_mclk);
    t_regs;
    t_branch;
    t_mem;
    t_bits;
    tally_and_finish;
  end
endmodule // cie_core_test
`default_nettype wire
